// ### hdl/cptbc_pkg.sv
// Functional notes
// - six-bit slack sets data the link may send after available drops.
// - utopia modes use only slack bits 2:0 as transfers before full.
// - utopia level 2 slack zero means five transfers.
// - utopia level 3 slack zero or one drops direct available after start of cell.
// - packet modes count four-byte groups; slack is capped at 56.
// - packet level 2 slack zero means one group.
// - packet level 3 8-bit slack zero means one group.
// - packet level 3 16/32-bit slack zero or one means two groups.
// - a packet of 4x+1 to 4x+4 bytes takes x+1 groups.
// - parity sense clear means odd parity, set means even parity.
// - polarity invert flips polled, direct and selected-port available outputs.
// - byte swap picks first byte from low lane instead of top lane.
// - header check pass enable carries the HEC byte with cell data.
// - any tx bus clock activity sets the clock-seen latch.
// - any parity mismatch on a transfer sets the parity error latch.
// - parity irq needs latch, its enable and the port group enable.
// - summary flag from enabled latches; low interrupt when summary enabled.
package cptbc_pkg;

  // register indices; byte address is four times the index
  localparam logic [11:0] CPTBC_IDX_CONTROL = 12'h030;
  localparam logic [11:0] CPTBC_IDX_STATUS  = 12'h032;
  localparam logic [11:0] CPTBC_IDX_IRQ_EN  = 12'h034;
  localparam logic [11:0] CPTBC_IDX_CONFIG  = 12'h100;
  localparam logic [11:0] CPTBC_IDX_GLOBAL  = 12'h101;

  localparam int CPTBC_REG_W = 16;

  // control register fields
  localparam int CPTBC_SLACK_LSB  = 8;
  localparam int CPTBC_SLACK_W    = 6;
  localparam int CPTBC_PAR_BIT    = 3;
  localparam int CPTBC_INV_BIT    = 2;
  localparam int CPTBC_SWAP_BIT   = 1;
  localparam int CPTBC_HEC_BIT    = 0;
  localparam logic [15:0] CPTBC_CONTROL_RST = 16'h0000;
  localparam logic [15:0] CPTBC_CONTROL_MSK = 16'h3F0F;

  // status and enable fields
  localparam int CPTBC_CLK_SEEN_BIT = 1;
  localparam int CPTBC_PAR_ERR_BIT  = 0;
  localparam logic [15:0] CPTBC_IRQ_EN_RST = 16'h0000;
  localparam logic [15:0] CPTBC_IRQ_EN_MSK = 16'h0001;

  // configuration: bus mode and width
  localparam int CPTBC_MODE_LSB  = 0;
  localparam int CPTBC_WIDTH_LSB = 2;
  localparam logic [15:0] CPTBC_CONFIG_RST = 16'h0000;
  localparam logic [15:0] CPTBC_CONFIG_MSK = 16'h000F;

  // global register: summary flag status and its enables
  localparam int CPTBC_SUM_FLAG_BIT = 0;
  localparam int CPTBC_SUM_EN_BIT   = 1;
  localparam int CPTBC_GRP_EN_BIT   = 2;
  localparam logic [15:0] CPTBC_GLOBAL_RST = 16'h0000;
  localparam logic [15:0] CPTBC_GLOBAL_MSK = 16'h0006;

  // slack defaults and limits
  localparam logic [5:0] CPTBC_U2_DEFAULT  = 6'd5;
  localparam logic [5:0] CPTBC_P_DEFAULT   = 6'd1;
  localparam logic [5:0] CPTBC_P3W_DEFAULT = 6'd2;
  localparam logic [5:0] CPTBC_SLACK_MAX   = 6'h38;
  localparam logic [5:0] CPTBC_SLACK_ONE   = 6'd1;
  localparam logic [2:0] CPTBC_GROUP_BYTES = 3'd4;

  localparam logic [1:0] CPTBC_RESP_OKAY   = 2'b00;
  localparam logic [1:0] CPTBC_RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    CPTBC_UTOPIA2, CPTBC_UTOPIA3, CPTBC_PACKET2, CPTBC_PACKET3
  } cptbc_mode_t;

  typedef enum logic [1:0] {
    CPTBC_W8, CPTBC_W16, CPTBC_W32, CPTBC_WRSV
  } cptbc_width_t;

  typedef struct packed {
    logic [31:0] data;
    logic        parity;
    logic        enable;
    logic        soc;
    logic        eop;
    logic [1:0]  mod;
  } cptbc_bus_t;

  typedef struct packed {
    logic [5:0] slack;
    logic       parity_sense_select;
    logic       available_polarity_invert;
    logic       byte_order_swap_enable;
    logic       header_check_pass_enable;
  } cptbc_ctrl_t;

endpackage

// ### hdl/cptbc_top.sv
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
module cptbc_top
  import cptbc_pkg::*;
#(
  parameter int FIFO_UNITS = 64,
  parameter int CELL_XFERS = 13
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // axi4-lite slave
  input  wire logic [13:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [13:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // transmit bus from the link layer
  input  wire logic        tx_bus_clock,
  input  wire logic [31:0] tx_bus_data,
  input  wire logic        tx_bus_parity_line,
  input  wire logic        tx_bus_enable,
  input  wire logic        tx_bus_soc,
  input  wire logic        tx_bus_eop,
  input  wire logic [1:0]  tx_bus_mod,
  output logic             polled_port_available,
  output logic             direct_unit_available,
  output logic             selected_port_available,
  // fifo side
  input  wire logic        fifo_unit_pop,
  output logic [31:0]      tx_word,
  output logic             tx_word_valid,
  output logic             tx_word_hec,
  output logic             fifo_unit_push,
  // interrupts
  output logic             irq,
  output logic             irq_n
);

  // 8-bit used count
  if (FIFO_UNITS < CELL_XFERS || FIFO_UNITS > 255 || CELL_XFERS < 1) begin
    $error("cptbc_top: unsupported fifo or cell size");
  end

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  logic [15:0] control_reg, control_next;
  logic [15:0] status_reg, status_next;
  logic [15:0] irq_en_reg, irq_en_next;
  logic [15:0] config_reg, config_next;
  logic [15:0] global_reg, global_next;
  logic [11:0] aw_idx_reg;
  logic        aw_have_reg;
  logic [15:0] w_data_reg;
  logic [1:0]  w_strb_reg;
  logic        w_have_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        rvalid_reg;
  logic [1:0]  rresp_reg;
  logic [31:0] rdata_reg;

  function automatic logic mapped(input logic [11:0] idx);
    mapped = (idx == CPTBC_IDX_CONTROL) || (idx == CPTBC_IDX_STATUS) ||
             (idx == CPTBC_IDX_IRQ_EN) || (idx == CPTBC_IDX_CONFIG) ||
             (idx == CPTBC_IDX_GLOBAL);
  endfunction

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] val,
                                        input logic [1:0] strb, input logic [15:0] msk);
    logic [15:0] m;
    m = {{8{strb[1]}}, {8{strb[0]}}};
    merge = ((old & ~m) | (val & m)) & msk;
  endfunction

  wire        aw_take  = s_axi_awvalid && !aw_have_reg;
  wire        w_take   = s_axi_wvalid && !w_have_reg;
  wire        wr_fire  = aw_have_reg && w_have_reg && !bvalid_reg;
  wire        ar_take  = s_axi_arvalid && !rvalid_reg;
  wire [11:0] ar_idx   = s_axi_araddr[13:2];
  wire        wr_ctl   = wr_fire && aw_idx_reg == CPTBC_IDX_CONTROL;
  wire        wr_sts   = wr_fire && aw_idx_reg == CPTBC_IDX_STATUS;
  wire        wr_ien   = wr_fire && aw_idx_reg == CPTBC_IDX_IRQ_EN;
  wire        wr_cfg   = wr_fire && aw_idx_reg == CPTBC_IDX_CONFIG;
  wire        wr_glb   = wr_fire && aw_idx_reg == CPTBC_IDX_GLOBAL;
  wire [15:0] w1c_mask = wr_sts ? (w_data_reg & {{8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}})
                                : 16'h0000;

  assign s_axi_awready = !aw_have_reg;
  assign s_axi_wready  = !w_have_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;

  wire [15:0] rd_word =
    (ar_idx == CPTBC_IDX_CONTROL) ? control_reg :
    (ar_idx == CPTBC_IDX_STATUS)  ? status_reg  :
    (ar_idx == CPTBC_IDX_IRQ_EN)  ? irq_en_reg  :
    (ar_idx == CPTBC_IDX_CONFIG)  ? config_reg  :
    (ar_idx == CPTBC_IDX_GLOBAL)  ? global_reg  : 16'h0000;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      aw_have_reg <= 1'b0;
      w_have_reg  <= 1'b0;
      aw_idx_reg  <= 12'h000;
      w_data_reg  <= 16'h0000;
      w_strb_reg  <= 2'b00;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= CPTBC_RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_have_reg <= 1'b1;
        aw_idx_reg  <= s_axi_awaddr[13:2];
      end
      if (w_take) begin
        w_have_reg <= 1'b1;
        w_data_reg <= s_axi_wdata[15:0];
        w_strb_reg <= s_axi_wstrb[1:0];
      end
      if (wr_fire) begin
        aw_have_reg <= 1'b0;
        w_have_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= mapped(aw_idx_reg) ? CPTBC_RESP_OKAY : CPTBC_RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= CPTBC_RESP_OKAY;
      rdata_reg  <= 32'h0000_0000;
    end else if (ar_take) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= mapped(ar_idx) ? CPTBC_RESP_OKAY : CPTBC_RESP_SLVERR;
      rdata_reg  <= {16'h0000, rd_word};
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // configuration decode
  // ----------------------------------------------------------------
  cptbc_ctrl_t  ctrl;
  cptbc_mode_t  mode;
  cptbc_width_t width;
  assign ctrl.slack = control_reg[CPTBC_SLACK_LSB +: CPTBC_SLACK_W];
  assign ctrl.parity_sense_select       = control_reg[CPTBC_PAR_BIT];
  assign ctrl.available_polarity_invert = control_reg[CPTBC_INV_BIT];
  assign ctrl.byte_order_swap_enable    = control_reg[CPTBC_SWAP_BIT];
  assign ctrl.header_check_pass_enable  = control_reg[CPTBC_HEC_BIT];
  assign mode  = cptbc_mode_t'(config_reg[CPTBC_MODE_LSB +: 2]);
  assign width = cptbc_width_t'(config_reg[CPTBC_WIDTH_LSB +: 2]);

  wire is_utopia = (mode == CPTBC_UTOPIA2) || (mode == CPTBC_UTOPIA3);

  // effective slack in transfers (utopia) or four-byte groups (packet)
  function automatic logic [5:0] eff_slack(input cptbc_mode_t m, input cptbc_width_t w,
                                           input logic [5:0] raw);
    logic [5:0] low;
    low = {3'b000, raw[2:0]};
    eff_slack = raw;
    unique case (m)
      CPTBC_UTOPIA2: eff_slack = (low == 6'd0) ? CPTBC_U2_DEFAULT : low;
      CPTBC_UTOPIA3: eff_slack = low;
      CPTBC_PACKET2: eff_slack = (raw == 6'd0) ? CPTBC_P_DEFAULT : raw;
      CPTBC_PACKET3: begin
        if (w == CPTBC_W8)
          eff_slack = (raw == 6'd0) ? CPTBC_P_DEFAULT : raw;
        else
          eff_slack = (raw <= CPTBC_SLACK_ONE) ? CPTBC_P3W_DEFAULT : raw;
      end
    endcase
    if (m == CPTBC_PACKET2 || m == CPTBC_PACKET3)
      if (eff_slack > CPTBC_SLACK_MAX) eff_slack = CPTBC_SLACK_MAX;
  endfunction

  wire [5:0] slack_eff = eff_slack(mode, width, ctrl.slack);
  wire       u3_default = (mode == CPTBC_UTOPIA3) && (ctrl.slack[2:0] <= 3'd1);

  // ----------------------------------------------------------------
  // link input synchronisers
  // ----------------------------------------------------------------
  // the link launches on its rising edge; sampling at the falling edge
  // lands in the middle of the data window after the same two-flop delay
  cptbc_bus_t bus_in, bus_s1, bus_s2;
  logic       clk_s1, clk_s2, clk_s3;
  assign bus_in = '{data: tx_bus_data, parity: tx_bus_parity_line,
                    enable: tx_bus_enable, soc: tx_bus_soc,
                    eop: tx_bus_eop, mod: tx_bus_mod};

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      bus_s1 <= '0;
      bus_s2 <= '0;
      clk_s1 <= 1'b0;
      clk_s2 <= 1'b0;
      clk_s3 <= 1'b0;
    end else begin
      bus_s1 <= bus_in;
      bus_s2 <= bus_s1;
      clk_s1 <= tx_bus_clock;
      clk_s2 <= clk_s1;
      clk_s3 <= clk_s2;
    end
  end

  wire clk_edge = clk_s2 ^ clk_s3;
  wire sample   = clk_s3 && !clk_s2;
  wire xfer     = sample && bus_s2.enable;

  // ----------------------------------------------------------------
  // parity and byte order
  // ----------------------------------------------------------------
  wire [31:0] wmask = (width == CPTBC_W8)  ? 32'h0000_00FF :
                      (width == CPTBC_W16) ? 32'h0000_FFFF : 32'hFFFF_FFFF;
  wire        odd_par  = ~^(bus_s2.data & wmask);
  wire        exp_par  = ctrl.parity_sense_select ? ~odd_par : odd_par;
  wire        par_err  = xfer && (exp_par != bus_s2.parity);

  function automatic logic [31:0] swap_bytes(input logic [31:0] d, input cptbc_width_t w);
    unique case (w)
      CPTBC_W16: swap_bytes = {16'h0000, d[7:0], d[15:8]};
      CPTBC_W32: swap_bytes = {d[7:0], d[15:8], d[23:16], d[31:24]};
      default:   swap_bytes = d;
    endcase
  endfunction

  // output word keeps the first byte in the top lane of its width
  wire [31:0] word_ordered = ctrl.byte_order_swap_enable ?
                             swap_bytes(bus_s2.data & wmask, width) :
                             (bus_s2.data & wmask);

  // ----------------------------------------------------------------
  // fifo space accounting
  // ----------------------------------------------------------------
  logic [7:0] used_reg, used_next;
  logic [2:0] fill_reg, fill_next;
  logic       push;
  logic       drop_reg;

  wire [2:0] width_bytes = (width == CPTBC_W8)  ? 3'd1 :
                           (width == CPTBC_W16) ? 3'd2 : 3'd4;
  wire [2:0] last_bytes  = (bus_s2.mod == 2'b00) ? width_bytes : {1'b0, bus_s2.mod};
  wire [2:0] xfer_bytes  = bus_s2.eop ? last_bytes : width_bytes;
  wire [3:0] fill_sum    = {1'b0, fill_reg} + {1'b0, xfer_bytes};

  always_comb begin
    push      = 1'b0;
    fill_next = fill_reg;
    if (xfer) begin
      if (is_utopia) begin
        push = 1'b1;
      end else if (bus_s2.eop || fill_sum >= {1'b0, CPTBC_GROUP_BYTES}) begin
        push      = 1'b1;
        fill_next = bus_s2.eop ? 3'd0 : 3'(fill_sum - {1'b0, CPTBC_GROUP_BYTES});
      end else begin
        fill_next = fill_sum[2:0];
      end
    end
    used_next = used_reg;
    if (push && !fifo_unit_pop)
      used_next = used_reg + 8'd1;
    else if (!push && fifo_unit_pop && used_reg != 8'd0)
      used_next = used_reg - 8'd1;
  end

  wire [7:0] free_units = 8'(FIFO_UNITS) - used_reg;
  wire       space_ok   = free_units > {2'b00, slack_eff};
  wire       cell_room  = free_units >= 8'(CELL_XFERS);
  wire       avail_poll = space_ok;
  wire       avail_dir  = u3_default ? (cell_room && !drop_reg) : space_ok;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      used_reg <= 8'd0;
      fill_reg <= 3'd0;
      drop_reg <= 1'b0;
    end else begin
      used_reg <= used_next;
      fill_reg <= fill_next;
      if (xfer && bus_s2.soc)
        drop_reg <= 1'b1;
      else if (!u3_default || (drop_reg && bus_s2.eop && xfer))
        drop_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      polled_port_available   <= 1'b0;
      direct_unit_available   <= 1'b0;
      selected_port_available <= 1'b0;
      tx_word                 <= 32'h0000_0000;
      tx_word_valid           <= 1'b0;
      tx_word_hec             <= 1'b0;
      fifo_unit_push          <= 1'b0;
    end else begin
      polled_port_available   <= avail_poll ^ ctrl.available_polarity_invert;
      direct_unit_available   <= avail_dir ^ ctrl.available_polarity_invert;
      selected_port_available <= avail_dir ^ ctrl.available_polarity_invert;
      tx_word                 <= xfer ? word_ordered : tx_word;
      tx_word_valid           <= xfer;
      tx_word_hec             <= is_utopia && ctrl.header_check_pass_enable;
      fifo_unit_push          <= push;
    end
  end

  // ----------------------------------------------------------------
  // registers, latches and interrupt
  // ----------------------------------------------------------------
  wire [15:0] events = ({15'h0000, clk_edge} << CPTBC_CLK_SEEN_BIT) |
                       ({15'h0000, par_err} << CPTBC_PAR_ERR_BIT);
  wire summary = |(status_reg & irq_en_reg) && global_reg[CPTBC_GRP_EN_BIT];
  wire irq_out = summary && global_reg[CPTBC_SUM_EN_BIT];

  always_comb begin
    control_next = wr_ctl ? merge(control_reg, w_data_reg, w_strb_reg, CPTBC_CONTROL_MSK)
                          : control_reg;
    irq_en_next  = wr_ien ? merge(irq_en_reg, w_data_reg, w_strb_reg, CPTBC_IRQ_EN_MSK)
                          : irq_en_reg;
    config_next  = wr_cfg ? merge(config_reg, w_data_reg, w_strb_reg, CPTBC_CONFIG_MSK)
                          : config_reg;
    global_next  = wr_glb ? merge(global_reg, w_data_reg, w_strb_reg, CPTBC_GLOBAL_MSK)
                          : global_reg;
    global_next[CPTBC_SUM_FLAG_BIT] = summary;
    status_next  = (status_reg & ~w1c_mask) | events;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      control_reg <= CPTBC_CONTROL_RST;
      status_reg  <= 16'h0000;
      irq_en_reg  <= CPTBC_IRQ_EN_RST;
      config_reg  <= CPTBC_CONFIG_RST;
      global_reg  <= CPTBC_GLOBAL_RST;
      irq         <= 1'b0;
      irq_n       <= 1'b1;
    end else begin
      control_reg <= control_next;
      status_reg  <= status_next;
      irq_en_reg  <= irq_en_next;
      config_reg  <= config_next;
      global_reg  <= global_next;
      irq         <= irq_out;
      irq_n       <= !irq_out;
    end
  end

endmodule

// ### bench/cptbc_checker.sv
`timescale 1ns/1ps
module cptbc_checker
  import cptbc_pkg::*;
(
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        rst_n,
  // register bus answers
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // transmit path and interrupts
  input wire logic [31:0] tx_word,
  input wire logic        tx_word_valid,
  input wire logic        fifo_unit_push,
  input wire logic        irq,
  input wire logic        irq_n
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_r_answer;
    s_axi_rvalid && (s_axi_rdata[31:16] == 16'h0000);
  endsequence

  property p_irq_comp;
    irq_n == !irq;
  endproperty
  a_irq_comp: assert property (p_irq_comp) else $error("irq_n not complement of irq");
  property p_b_stand;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_stand: assert property (p_b_stand) else $error("write answer dropped early");
  property p_r_stand;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_stand: assert property (p_r_stand) else $error("read answer dropped early");
  property p_ar_ans;
    s_ar_take |=> s_r_answer;
  endproperty
  a_ar_ans: assert property (p_ar_ans) else $error("read answer late or wide");
  property p_ar_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_block: assert property (p_ar_block) else $error("read taken while answer held");
  property p_word_chg;
    $changed(tx_word) |-> tx_word_valid;
  endproperty
  a_word_chg: assert property (p_word_chg) else $error("word moved without a transfer");
  property p_valid_pulse;
    tx_word_valid |=> !tx_word_valid;
  endproperty
  a_valid_pulse: assert property (p_valid_pulse) else $error("word valid too long");
  property p_push_pulse;
    fifo_unit_push |=> !fifo_unit_push ##1 !fifo_unit_push;
  endproperty
  a_push_pulse: assert property (p_push_pulse) else $error("push pulses too dense");
endmodule

bind cptbc_top cptbc_checker u_chk (.sys_clk, .rst_n, .s_axi_bvalid, .s_axi_bready,
  .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
  .tx_word, .tx_word_valid, .fifo_unit_push, .irq, .irq_n);

// ### bench/cptbc_link_model.sv
`timescale 1ns/1ps
module cptbc_link_model (
  // link bus toward the device
  output logic        tx_bus_clock,
  output logic [31:0] tx_bus_data,
  output logic        tx_bus_parity_line,
  output logic        tx_bus_enable,
  output logic        tx_bus_soc,
  output logic        tx_bus_eop,
  output logic [1:0]  tx_bus_mod
);
  logic parity_sense = 1'b0;
  initial begin
    tx_bus_clock = 1'b0;
    tx_bus_data = 32'h0;
    tx_bus_parity_line = 1'b1;
    tx_bus_enable = 1'b0;
    tx_bus_soc = 1'b0;
    tx_bus_eop = 1'b0;
    tx_bus_mod = 2'h0;
  end
  // one transfer: data moves on the rising edge and holds a whole period
  task automatic send(input logic [31:0] d, input logic s, input logic e,
                      input logic [1:0] m, input logic bad);
    #7;
    tx_bus_data        <= d;
    tx_bus_parity_line <= ^d ^ ~parity_sense ^ bad;
    tx_bus_enable      <= 1'b1;
    tx_bus_soc         <= s;
    tx_bus_eop         <= e;
    tx_bus_mod         <= m;
    tx_bus_clock       <= 1'b1;
    #80;
    tx_bus_clock <= 1'b0;
    #80;
  endtask
  // clock stands still; released data is inverted so a stale sample cannot match
  task automatic idle;
    tx_bus_enable <= 1'b0;
    tx_bus_data   <= ~tx_bus_data;
  endtask
endmodule

// ### bench/cell_packet_tx_bus_control_tb.sv
`timescale 1ns/1ps
module cell_packet_tx_bus_control_tb;
  import cptbc_pkg::*;
  localparam logic [13:0] A_CTL = {CPTBC_IDX_CONTROL, 2'b00};
  localparam logic [13:0] A_STS = {CPTBC_IDX_STATUS, 2'b00};
  localparam logic [13:0] A_IEN = {CPTBC_IDX_IRQ_EN, 2'b00};
  localparam logic [13:0] A_CFG = {CPTBC_IDX_CONFIG, 2'b00};
  localparam logic [13:0] A_GLB = {CPTBC_IDX_GLOBAL, 2'b00};
  logic        sys_clk, rst_n, fifo_unit_pop, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic [13:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, tx_bus_data, tx_word, rdv;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, tx_bus_mod, rsp;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, tx_bus_clock, tx_bus_parity_line, tx_bus_enable;
  logic        tx_bus_soc, tx_bus_eop, tx_word_valid, tx_word_hec, fifo_unit_push, irq, irq_n;
  logic        polled_port_available, direct_unit_available, selected_port_available;
  int          fail_count = 0, checks_done = 0, pushes = 0, p0;

  cptbc_top #(.FIFO_UNITS(8), .CELL_XFERS(2))
    uut (.sys_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_bus_clock, .tx_bus_data,
    .tx_bus_parity_line, .tx_bus_enable, .tx_bus_soc, .tx_bus_eop, .tx_bus_mod,
    .polled_port_available, .direct_unit_available, .selected_port_available,
    .fifo_unit_pop, .tx_word, .tx_word_valid, .tx_word_hec, .fifo_unit_push, .irq, .irq_n);
  cptbc_link_model link (.tx_bus_clock, .tx_bus_data, .tx_bus_parity_line, .tx_bus_enable,
    .tx_bus_soc, .tx_bus_eop, .tx_bus_mod);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [13:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [13:0] a);
    @(posedge sys_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rdv = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rc(input logic [13:0] a, input logic [31:0] exp);
    rd(a);
    chk(rdv, exp);
  endtask
  // outputs are registered, so let two edges land before looking
  task automatic settle;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask
  task automatic tx(input logic [31:0] d, input logic s, input logic e,
                    input logic [1:0] m, input logic bad);
    link.send(d, s, e, m, bad);
    settle();
    settle();
  endtask
  task automatic pop(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      fifo_unit_pop <= 1'b1;
      @(posedge sys_clk);
      fifo_unit_pop <= 1'b0;
    end
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  initial begin
    #100000;
    fail_count++;
    wrap_up();
  end
  always @(posedge sys_clk) if (fifo_unit_push === 1'b1) pushes <= pushes + 1;

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst_n = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    fifo_unit_pop = 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    rc(A_CTL, 32'h0);
    rc(A_IEN, 32'h0);
    rd(14'h00D8);
    chk(rsp, CPTBC_RESP_SLVERR);
    wr(A_CFG, 32'h8);
    wr(A_CTL, 32'hFFFF);
    rc(A_CTL, 32'h3F0F);
    chk(polled_port_available, 1'b0);
    chk(direct_unit_available, 1'b0);
    wr(A_CTL, 32'h0);
    settle();
    chk(selected_port_available, 1'b1);
    // utopia level 2 default slack of five
    tx(32'h11223344, 1'b1, 1'b0, 2'h0, 1'b0);
    chk(tx_word, 32'h11223344);
    tx(32'h55667788, 1'b0, 1'b0, 2'h0, 1'b0);
    chk(polled_port_available, 1'b1);
    tx(32'h0, 1'b0, 1'b0, 2'h0, 1'b0);
    link.idle();
    chk(polled_port_available, 1'b0);
    chk(direct_unit_available, 1'b0);
    chk(pushes, 3);
    wr(A_CTL, 32'h0B00);
    settle();
    chk(polled_port_available, 1'b1);
    rc(A_STS, 32'h2);
    wr(A_STS, 32'h2);
    rc(A_STS, 32'h0);
    pop(3);
    wr(A_CTL, 32'h3);
    tx(32'h11223344, 1'b1, 1'b0, 2'h0, 1'b0);
    chk(tx_word, 32'h44332211);
    chk(tx_word_hec, 1'b1);
    wr(A_CTL, 32'h8);
    settle();
    chk(tx_word_hec, 1'b0);
    link.parity_sense = 1'b1;
    tx(32'h0, 1'b0, 1'b0, 2'h0, 1'b0);
    rc(A_STS, 32'h2);
    tx(32'h0, 1'b0, 1'b0, 2'h0, 1'b1);
    link.idle();
    rc(A_STS, 32'h3);
    wr(A_IEN, 32'h1);
    settle();
    chk(irq, 1'b0);
    wr(A_GLB, 32'h6);
    settle();
    chk(irq, 1'b1);
    chk(irq_n, 1'b0);
    rc(A_GLB, 32'h7);
    wr(A_GLB, 32'h4);
    settle();
    chk(irq, 1'b0);
    wr(A_GLB, 32'h6);
    wr(A_STS, 32'h3);
    settle();
    chk(irq, 1'b0);
    rc(A_STS, 32'h0);
    wr(A_CFG, 32'h9);
    tx(32'h1, 1'b1, 1'b0, 2'h0, 1'b0);
    chk(direct_unit_available, 1'b0);
    tx(32'h2, 1'b0, 1'b1, 2'h0, 1'b0);
    chk(direct_unit_available, 1'b1);
    pop(8);
    // packet level 2, 32-bit: groups and default slack of one
    link.parity_sense = 1'b0;
    wr(A_CFG, 32'hA);
    wr(A_CTL, 32'h0);
    p0 = pushes;
    tx(32'hA1A2A3A4, 1'b1, 1'b0, 2'h0, 1'b0);
    tx(32'hB1B2B3B4, 1'b0, 1'b1, 2'h1, 1'b0);
    chk(pushes - p0, 2);
    tx(32'hC1C2C3C4, 1'b1, 1'b1, 2'h2, 1'b0);
    chk(pushes - p0, 3);
    tx(32'hD1D2D3D4, 1'b1, 1'b0, 2'h0, 1'b0);
    repeat (2) tx(32'hE1E2E3E4, 1'b0, 1'b0, 2'h0, 1'b0);
    chk(selected_port_available, 1'b1);
    tx(32'hF1F2F3F4, 1'b0, 1'b1, 2'h0, 1'b0);
    link.idle();
    chk(selected_port_available, 1'b0);
    chk(direct_unit_available, 1'b0);
    wr(A_CFG, 32'h3);
    settle();
    chk(polled_port_available, 1'b0);
    pop(1);
    wr(A_CFG, 32'hB);
    settle();
    chk(polled_port_available, 1'b0);
    pop(8);
    wr(A_CTL, 32'h3F00);
    settle();
    chk(polled_port_available, 1'b0);
    wrap_up();
  end
endmodule
